// >>> logic/rerc_consts.vh
// Constants for the error record feature, control and syndrome bank
`ifndef RERC_CONSTS_VH
`define RERC_CONSTS_VH

// ----------------------------------------------------------------------------
// Per-record window layout, 64 bytes per record
// ----------------------------------------------------------------------------
`define RERC_REC_STRIDE_LOG2 6
`define RERC_OFF_FEATURE     6'h00
`define RERC_OFF_CONTROL     6'h08
`define RERC_OFF_MISC0       6'h20

// ----------------------------------------------------------------------------
// System register command codes
// ----------------------------------------------------------------------------
`define RERC_SR_SELECTOR     3'h0
`define RERC_SR_FEATURE      3'h1
`define RERC_SR_MISC64       3'h2
`define RERC_SR_MISC_LO      3'h3
`define RERC_SR_MISC_HI      3'h4
`define RERC_SR_CONTROL      3'h5

// ----------------------------------------------------------------------------
// Capability encodings
// ----------------------------------------------------------------------------
`define RERC_CAP_NONE        2'h0
`define RERC_CAP_ALWAYS      2'h1
`define RERC_CAP_SINGLE      2'h2
`define RERC_CAP_SPLIT       2'h3
`define RERC_CNT_NONE        3'h0
`define RERC_CNT_8           3'h2
`define RERC_CNT_16          3'h4

// ----------------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------------
`define RERC_CTL_LOG         0
`define RERC_CTL_RECOV       2
`define RERC_CTL_FAULT       3
`define RERC_CTL_ABORT       4
`define RERC_CTL_WR_RECOV    8
`define RERC_CTL_RD_RECOV    9
`define RERC_CTL_WR_FAULT    10
`define RERC_CTL_RD_FAULT    11
`define RERC_CTL_WR_ABORT    12
`define RERC_CTL_RD_ABORT    13
`define RERC_CTL_RESET       32'h0000_0000

// ----------------------------------------------------------------------------
// Syndrome layout
// ----------------------------------------------------------------------------
`define RERC_C16_LO          32
`define RERC_C16_HI          46
`define RERC_C16_OVF         47
`define RERC_C8_LO           32
`define RERC_C8_HI           38
`define RERC_C8_OVF          39
`define RERC_FAULT_LO        0
`define RERC_FAULT_HI        7
`define RERC_RECOV_LO        8
`define RERC_RECOV_HI        15
`define RERC_MISC_RESET      64'h0000_0000_0000_0000

`endif

// >>> logic/rerc_counter.v
// Error record bank: feature, control and first syndrome register with counter
`timescale 1ns/1ps
`include "rerc_consts.vh"

// Operation
// - Abort capability field reports four cases; control bit zero when absent or always.
// - Fault interrupt capability encoding; control bit reads zero, ignores writes if 00/01.
// - Recovery interrupt capability same encoding; control bit zero when absent or always.
// - Feature bits three to two return a fixed implementer constant.
// - First record logging field reads 01 always-on or 10 control-bit enabled.
// - Non-first records read an all-zero feature register.
// - Advertised counter type plus countable record gives architected counter layout.
// - Feature settings come from the node's lowest-indexed record.
// - Writing zero to a syndrome field withdraws its interrupt request.
// - Syndrome interrupts start disabled at cold reset; software enables via control.
// - Memory view decodes syndrome register at 0x20 plus 64 times index.
// - System access uses record selector; 64-bit whole, 32-bit low and high views.
// - Sixteen-bit type: counter bits 46..32, overflow flag bit 47.
// - Eight-bit type: counter bits 38..32, overflow flag bit 39.
// - Counter increments by one for each corrected error detected; here only while the node's logging enable is on.
// - Wrap through zero sets the overflow flag until software changes it.
// - Overflow flag and status overflow bit may disturb each other unknowably.
// - Counter and flag unknown at cold reset, kept through error-recovery reset.
// - Without standard counter all 64 syndrome bits are implementer-defined.
// - Counter type 000 none, 010 eight-bit, 100 sixteen-bit.
// - Repeat counter bit 15 reads zero for single-counter layouts.
module rerc_counter #(
	parameter       NUM_REC       = 4,
	parameter       REC_W         = 2,
	parameter       RECS_PER_NODE = 2,
	parameter [2:0] CNT_TYPE      = `RERC_CNT_16,
	parameter [1:0] ABORT_CAP     = `RERC_CAP_SINGLE,
	parameter [1:0] FAULT_CAP     = `RERC_CAP_SINGLE,
	parameter [1:0] RECOV_CAP     = `RERC_CAP_SPLIT,
	parameter [1:0] LOG_CAP       = `RERC_CAP_SINGLE,
	parameter [1:0] IMPL_FR_BITS  = 2'h1
) (
	input  wire                      core_clk,
	input  wire                      reset_n,
	input  wire                      er_reset,
	input  wire [NUM_REC-1:0]        ce_event,
	input  wire                      mm_valid,
	input  wire                      mm_write,
	input  wire [REC_W+5:0]          mm_addr,
	input  wire [63:0]               mm_wdata,
	output reg  [63:0]               mm_rdata,
	output reg                       mm_done,
	output reg                       mm_err,
	input  wire                      sr_valid,
	input  wire                      sr_write,
	input  wire [2:0]                sr_cmd,
	input  wire [63:0]               sr_wdata,
	output reg  [63:0]               sr_rdata,
	output reg                       sr_done,
	output reg  [REC_W-1:0]          record_selector,
	output reg                       fault_irq_req,
	output reg                       recovery_irq_req
);

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	reg [63:0] misc_r [0:NUM_REC-1];
	reg [31:0] ctrl_r [0:NUM_REC-1];
	reg [63:0] misc_nxt [0:NUM_REC-1];

	// ------------------------------------------------------------------------
	// Feature word of a node's first record
	// ------------------------------------------------------------------------
	wire [63:0] feature_first;
	assign feature_first = {48'h0, 1'b0,
		CNT_TYPE,
		2'h0, ABORT_CAP, FAULT_CAP, RECOV_CAP,
		IMPL_FR_BITS,
		LOG_CAP};

	// Writable control bits follow the capability fields
	function [31:0] cap_mask;
		input [1:0] cap;
		input integer single;
		input integer wbit;
		input integer rbit;
		begin
			cap_mask = 32'h0;
			if (cap == `RERC_CAP_SINGLE)
				cap_mask[single] = 1'b1;
			else if (cap == `RERC_CAP_SPLIT) begin
				cap_mask[wbit] = 1'b1;
				cap_mask[rbit] = 1'b1;
			end
		end
	endfunction

	wire [31:0] ctrl_wmask;
	assign ctrl_wmask = cap_mask(ABORT_CAP, `RERC_CTL_ABORT, `RERC_CTL_WR_ABORT, `RERC_CTL_RD_ABORT)
		| cap_mask(FAULT_CAP, `RERC_CTL_FAULT, `RERC_CTL_WR_FAULT, `RERC_CTL_RD_FAULT)
		| cap_mask(RECOV_CAP, `RERC_CTL_RECOV, `RERC_CTL_WR_RECOV, `RERC_CTL_RD_RECOV)
		| ((LOG_CAP == `RERC_CAP_SINGLE) ? 32'h1 : 32'h0);

	// Enable decode from a node's control word; split controls act as either
	function enab;
		input [1:0]  cap;
		input [31:0] c;
		input integer single;
		input integer wbit;
		input integer rbit;
		begin
			case (cap)
				`RERC_CAP_ALWAYS: enab = 1'b1;
				`RERC_CAP_SINGLE: enab = c[single];
				`RERC_CAP_SPLIT:  enab = c[wbit] | c[rbit];
				default:          enab = 1'b0;
			endcase
		end
	endfunction

	// Counter step; applied after any software write this cycle, so it steps the written count
	function [63:0] bump;
		input [63:0] v;
		reg   [15:0] c;
		begin
			bump = v;
			c    = 16'h0;
			if (CNT_TYPE == `RERC_CNT_16) begin
				c = {1'b0, v[`RERC_C16_HI:`RERC_C16_LO]} + 16'h1;
				bump[`RERC_C16_HI:`RERC_C16_LO] = c[14:0];
				if (c[15])
					bump[`RERC_C16_OVF] = 1'b1;
			end else if (CNT_TYPE == `RERC_CNT_8) begin
				c = {9'h0, v[`RERC_C8_HI:`RERC_C8_LO]} + 16'h1;
				bump[`RERC_C8_HI:`RERC_C8_LO] = c[6:0];
				if (c[7])
					bump[`RERC_C8_OVF] = 1'b1;
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// Access decode; the memory window wins a collision, the other waits
	// ------------------------------------------------------------------------
	reg             sr_take;
	reg             acc_on;
	reg             acc_wr;
	reg             acc_map;
	reg [REC_W-1:0] acc_rec;
	reg [5:0]       acc_off;
	reg [63:0]      acc_wdata;
	reg [63:0]      acc_lane;
	reg             acc_hi;

	always @* begin
		sr_take   = sr_valid & ~mm_valid;
		acc_on    = mm_valid | sr_take;
		acc_wr    = mm_valid ? mm_write : sr_write;
		acc_rec   = mm_valid ? mm_addr[REC_W+5:6] : record_selector;
		acc_off   = `RERC_OFF_MISC0;
		acc_wdata = mm_valid ? mm_wdata : sr_wdata;
		acc_lane  = 64'hffff_ffff_ffff_ffff;
		acc_hi    = 1'b0;
		if (mm_valid)
			acc_off = mm_addr[5:0];
		else begin
			case (sr_cmd)
				`RERC_SR_FEATURE: acc_off = `RERC_OFF_FEATURE;
				`RERC_SR_CONTROL: acc_off = `RERC_OFF_CONTROL;
				`RERC_SR_MISC_LO: acc_lane = 64'h0000_0000_ffff_ffff;
				`RERC_SR_MISC_HI: begin
					acc_lane  = 64'hffff_ffff_0000_0000;
					acc_wdata = {sr_wdata[31:0], 32'h0};
					acc_hi    = 1'b1;
				end
				`RERC_SR_SELECTOR: acc_off = 6'h3f;
				default: acc_off = `RERC_OFF_MISC0;
			endcase
		end
		acc_map = (acc_rec < NUM_REC) && (acc_off == `RERC_OFF_FEATURE
			|| acc_off == `RERC_OFF_CONTROL || acc_off == `RERC_OFF_MISC0);
	end

	// ------------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------------
	reg [63:0]  rd_val;
	integer     q;

	always @* begin
		rd_val = 64'h0;
		q      = (acc_rec / RECS_PER_NODE) * RECS_PER_NODE;
		if (acc_map) begin
			case (acc_off)
				`RERC_OFF_FEATURE:
					rd_val = (q == acc_rec) ? feature_first : 64'h0;
				`RERC_OFF_CONTROL:
					rd_val = (q == acc_rec) ? {32'h0, ctrl_r[acc_rec]} : 64'h0;
				`RERC_OFF_MISC0:
					rd_val = misc_r[acc_rec] & acc_lane;
				default: rd_val = 64'h0;
			endcase
			if (acc_hi)
				rd_val = {32'h0, rd_val[63:32]};
		end
	end

	// ------------------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------------------
	integer i;
	integer j;
	integer k;
	integer f;
	integer g;
	reg     wr_misc;
	reg     wr_ctrl;

	always @* begin
		wr_misc = acc_on & acc_wr & acc_map & (acc_off == `RERC_OFF_MISC0);
		wr_ctrl = acc_on & acc_wr & acc_map & (acc_off == `RERC_OFF_CONTROL)
			& ((acc_rec % RECS_PER_NODE) == 0);
	end

	// Next syndrome word: the software write lands first, then the count step,
	// so the step acts on the written value and a wrap of the old count in the same cycle is lost
	always @* begin
		g = 0;
		for (k = 0; k < NUM_REC; k = k + 1) begin
			g           = (k / RECS_PER_NODE) * RECS_PER_NODE;
			misc_nxt[k] = misc_r[k];
			// All 64 bits plain storage unless a counter is laid over them
			if (wr_misc && acc_rec == k)
				misc_nxt[k] = (misc_r[k] & ~acc_lane) | (acc_wdata & acc_lane);
			// The status overflow bit lives outside; writes here never touch it
			if (ce_event[k] && CNT_TYPE != `RERC_CNT_NONE
				&& enab(LOG_CAP, ctrl_r[g], `RERC_CTL_LOG, `RERC_CTL_LOG, `RERC_CTL_LOG))
				misc_nxt[k] = bump(misc_nxt[k]);
		end
	end

	// Counter and syndrome have no architected reset value; zero keeps sim clean
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < NUM_REC; i = i + 1) begin
				misc_r[i] <= `RERC_MISC_RESET;
				ctrl_r[i] <= `RERC_CTL_RESET;
			end
		end else begin
			for (i = 0; i < NUM_REC; i = i + 1) begin
				// Recovery reset only clears control; syndrome and count carry on
				misc_r[i] <= misc_nxt[i];
				if (er_reset)
					ctrl_r[i] <= `RERC_CTL_RESET;
				else if (wr_ctrl && acc_rec == i)
					ctrl_r[i] <= acc_wdata[31:0] & ctrl_wmask;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Answers, selector and interrupt requests
	// ------------------------------------------------------------------------
	reg fault_any;
	reg recov_any;

	always @* begin
		fault_any = 1'b0;
		recov_any = 1'b0;
		f         = 0;
		for (j = 0; j < NUM_REC; j = j + 1) begin
			f = (j / RECS_PER_NODE) * RECS_PER_NODE;
			// A zero field means quiescent, so writing zero drops the request
			if (|misc_r[j][`RERC_FAULT_HI:`RERC_FAULT_LO]
				&& enab(FAULT_CAP, ctrl_r[f], `RERC_CTL_FAULT, `RERC_CTL_WR_FAULT, `RERC_CTL_RD_FAULT))
				fault_any = 1'b1;
			if (|misc_r[j][`RERC_RECOV_HI:`RERC_RECOV_LO]
				&& enab(RECOV_CAP, ctrl_r[f], `RERC_CTL_RECOV, `RERC_CTL_WR_RECOV, `RERC_CTL_RD_RECOV))
				recov_any = 1'b1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mm_rdata         <= 64'h0;
			mm_done          <= 1'b0;
			mm_err           <= 1'b0;
			sr_rdata         <= 64'h0;
			sr_done          <= 1'b0;
			record_selector  <= {REC_W{1'b0}};
			fault_irq_req    <= 1'b0;
			recovery_irq_req <= 1'b0;
		end else begin
			mm_done          <= mm_valid;
			mm_err           <= mm_valid & ~acc_map;
			mm_rdata         <= (mm_valid && !mm_write) ? rd_val : 64'h0;
			sr_done          <= sr_take;
			fault_irq_req    <= fault_any;
			recovery_irq_req <= recov_any;
			if (sr_take && sr_cmd == `RERC_SR_SELECTOR) begin
				if (sr_write)
					record_selector <= sr_wdata[REC_W-1:0];
				sr_rdata <= sr_write ? 64'h0 : {{(64-REC_W){1'b0}}, record_selector};
			end else
				sr_rdata <= (sr_take && !sr_write) ? rd_val : 64'h0;
		end
	end

endmodule // rerc_counter

// >>> tb/rerc_counter_sva.sv
// Port-level assertion checker for the error record bank
`timescale 1ns/1ps
module rerc_counter_sva #(
	parameter       NUM_REC       = 4,
	parameter       REC_W         = 2,
	parameter       RECS_PER_NODE = 2,
	parameter [2:0] CNT_TYPE      = 3'h4
) (
	input wire             core_clk,
	input wire             reset_n,
	input wire             er_reset,
	input wire             mm_valid,
	input wire             mm_write,
	input wire [REC_W+5:0] mm_addr,
	input wire [63:0]      mm_rdata,
	input wire             mm_done,
	input wire             mm_err,
	input wire             sr_valid,
	input wire             sr_write,
	input wire [2:0]       sr_cmd,
	input wire [63:0]      sr_wdata,
	input wire             sr_done,
	input wire [REC_W-1:0] record_selector,
	input wire             fault_irq_req,
	input wire             recovery_irq_req
);
	wire [REC_W-1:0] rec_idx = mm_addr[REC_W+5:6];
	wire [5:0]       off     = mm_addr[5:0];
	wire             hit     = (rec_idx < NUM_REC) && (off == 6'h00 || off == 6'h08 || off == 6'h20);
	wire             feat_rd = mm_valid && !mm_write && hit && off == 6'h00;
	wire             first   = (rec_idx % RECS_PER_NODE) == 0;
	wire             sel_wr  = sr_valid && !mm_valid && sr_write && sr_cmd == 3'h0;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_mm_answer: assert property (mm_valid |=> mm_done && (mm_err == !$past(hit)))
		else $error("memory window answer or decode wrong");
	a_mm_idle: assert property (!mm_valid |=> !mm_done && !mm_err && mm_rdata == 64'h0)
		else $error("memory window answered without request");
	a_wr_quiet: assert property (mm_valid && mm_write |=> mm_rdata == 64'h0)
		else $error("write returned data");
	a_sr_answer: assert property (sr_valid && !mm_valid |=> sr_done)
		else $error("system access not answered");
	a_sr_refused: assert property (!(sr_valid && !mm_valid) |=> !sr_done)
		else $error("system access answered while not taken");
	a_sel_update: assert property (sel_wr |=> record_selector == $past(sr_wdata[REC_W-1:0]))
		else $error("selector not loaded");
	a_sel_hold: assert property (!sel_wr |=> $stable(record_selector))
		else $error("selector changed without write");
	a_feat_zero: assert property (feat_rd && !first |=> mm_rdata == 64'h0)
		else $error("non-first feature register not zero");
	a_feat_first: assert property (feat_rd && first |=> mm_rdata[15] == 1'b0 && mm_rdata[14:12] == CNT_TYPE
		&& (mm_rdata[1:0] == 2'h1 || mm_rdata[1:0] == 2'h2)) else $error("first feature register fields wrong");
	a_er_quiet: assert property (er_reset && !mm_valid && !sr_valid ##1 !mm_valid && !sr_valid
		|=> !fault_irq_req && !recovery_irq_req) else $error("interrupt survived recovery reset");

	c_feat_read: cover property (feat_rd);
	c_unmapped: cover property (mm_err);
	c_fault_up: cover property ($rose(fault_irq_req));
	c_recov_down: cover property ($fell(recovery_irq_req));
endmodule // rerc_counter_sva

bind rerc_counter rerc_counter_sva #(.NUM_REC(NUM_REC), .REC_W(REC_W), .RECS_PER_NODE(RECS_PER_NODE),
	.CNT_TYPE(CNT_TYPE)) sva_u (.core_clk(core_clk), .reset_n(reset_n), .er_reset(er_reset),
	.mm_valid(mm_valid), .mm_write(mm_write), .mm_addr(mm_addr), .mm_rdata(mm_rdata), .mm_done(mm_done),
	.mm_err(mm_err), .sr_valid(sr_valid), .sr_write(sr_write), .sr_cmd(sr_cmd), .sr_wdata(sr_wdata),
	.sr_done(sr_done), .record_selector(record_selector), .fault_irq_req(fault_irq_req),
	.recovery_irq_req(recovery_irq_req));

// >>> tb/tb_ras_error_record_counter.sv
// Self-checking testbench for the error record bank
`timescale 1ns/1ps
module tb_ras_error_record_counter;
	reg        core_clk, reset_n, er_reset, mm_valid, mm_write, sr_valid, sr_write, er;
	reg [3:0]  ce_event;
	reg [7:0]  mm_addr;
	reg [2:0]  sr_cmd;
	reg [63:0] mm_wdata, sr_wdata, rd;
	wire[63:0] mm_rdata, sr_rdata;
	wire       mm_done, mm_err, sr_done, fault_irq_req, recovery_irq_req;
	wire [1:0] record_selector;
	integer    n_mismatch, checks;

	rerc_counter dut_u (.core_clk(core_clk), .reset_n(reset_n), .er_reset(er_reset), .ce_event(ce_event),
		.mm_valid(mm_valid), .mm_write(mm_write), .mm_addr(mm_addr), .mm_wdata(mm_wdata), .mm_rdata(mm_rdata),
		.mm_done(mm_done), .mm_err(mm_err), .sr_valid(sr_valid), .sr_write(sr_write), .sr_cmd(sr_cmd),
		.sr_wdata(sr_wdata), .sr_rdata(sr_rdata), .sr_done(sr_done), .record_selector(record_selector),
		.fault_irq_req(fault_irq_req), .recovery_irq_req(recovery_irq_req));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task stop_test;
		begin
			if (n_mismatch == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task chk(input [63:0] got, input [63:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// Answer lands one edge after the request; a few spare edges before giving up
	task wait_ack(input sel);
		integer i;
		begin
			i = 0;
			while (((sel ? sr_done : mm_done) !== 1'b1) && i < 8) begin
				@(posedge core_clk);
				#1;
				i = i + 1;
			end
			if (i == 8) begin
				n_mismatch = n_mismatch + 1;
				stop_test;
			end
		end
	endtask

	task mm_acc(input w, input [7:0] a, input [63:0] d);
		begin
			@(posedge core_clk);
			mm_valid <= 1'b1; mm_write <= w; mm_addr <= a; mm_wdata <= d;
			@(posedge core_clk);
			mm_valid <= 1'b0;
			#1;
			wait_ack(1'b0);
			rd = mm_rdata;
			er = mm_err;
		end
	endtask

	task sr_acc(input w, input [2:0] c, input [63:0] d);
		begin
			@(posedge core_clk);
			sr_valid <= 1'b1; sr_write <= w; sr_cmd <= c; sr_wdata <= d;
			@(posedge core_clk);
			sr_valid <= 1'b0;
			#1;
			wait_ack(1'b1);
			rd = sr_rdata;
		end
	endtask

	task ev(input [3:0] m, input integer n);
		begin
			@(posedge core_clk);
			ce_event <= m;
			repeat (n) @(posedge core_clk);
			ce_event <= 4'h0;
		end
	endtask

	task t_feature;
		begin
			mm_acc(1'h0, 8'h00, 64'h0); chk(rd[15:0], 16'h42b6);
			mm_acc(1'h0, 8'h40, 64'h0); chk(rd, 64'h0);
			mm_acc(1'h0, 8'h80, 64'h0); chk(rd[15:0], 16'h42b6);
			mm_acc(1'h1, 8'h00, 64'hffff); mm_acc(1'h0, 8'h00, 64'h0); chk(rd[15:0], 16'h42b6);
			mm_acc(1'h0, 8'h10, 64'h0); chk(er, 1'h1);
			mm_acc(1'h1, 8'h08, 64'hffff_ffff_ffff_ffff); mm_acc(1'h0, 8'h08, 64'h0); chk(rd, 64'h319);
			mm_acc(1'h1, 8'h48, 64'h1); mm_acc(1'h0, 8'h48, 64'h0); chk(rd, 64'h0);
		end
	endtask

	task t_counter;
		begin
			mm_acc(1'h1, 8'h20, 64'h0000_7ffe_0000_0000);
			ev(4'h7, 2);
			mm_acc(1'h0, 8'h20, 64'h0); chk(rd, 64'h0000_8000_0000_0000);
			mm_acc(1'h0, 8'h60, 64'h0); chk(rd, 64'h0000_0002_0000_0000);
			mm_acc(1'h0, 8'ha0, 64'h0); chk(rd, 64'h0);
			ev(4'h1, 1);
			mm_acc(1'h0, 8'h20, 64'h0); chk(rd, 64'h0000_8001_0000_0000);
			mm_acc(1'h1, 8'h20, 64'h0); mm_acc(1'h0, 8'h20, 64'h0); chk(rd, 64'h0);
		end
	endtask

	task t_sysreg;
		begin
			sr_acc(1'h1, 3'h0, 64'h1); chk(record_selector, 2'h1);
			sr_acc(1'h0, 3'h2, 64'h0); chk(rd, 64'h0000_0002_0000_0000);
			sr_acc(1'h0, 3'h4, 64'h0); chk(rd, 64'h2);
			sr_acc(1'h1, 3'h3, 64'hffff_ffff_1234_0000); sr_acc(1'h0, 3'h2, 64'h0);
			chk(rd, 64'h0000_0002_1234_0000);
			sr_acc(1'h0, 3'h1, 64'h0); chk(rd, 64'h0);
			mm_acc(1'h1, 8'he0, 64'h0000_0000_00ab_0000); sr_acc(1'h1, 3'h0, 64'h3);
			sr_acc(1'h0, 3'h2, 64'h0); chk(rd, 64'h0000_0000_00ab_0000);
			sr_acc(1'h0, 3'h0, 64'h0); chk(rd[1:0], 2'h3);
		end
	endtask

	task t_irq;
		begin
			mm_acc(1'h1, 8'h20, 64'h55); @(posedge core_clk); #1;
			chk(fault_irq_req, 1'h1); chk(recovery_irq_req, 1'h0);
			mm_acc(1'h1, 8'h20, 64'h3c00); @(posedge core_clk); #1;
			chk(fault_irq_req, 1'h0); chk(recovery_irq_req, 1'h1);
			@(posedge core_clk); er_reset <= 1'b1;
			@(posedge core_clk); er_reset <= 1'b0;
			repeat (2) @(posedge core_clk); #1;
			chk(recovery_irq_req, 1'h0);
			mm_acc(1'h0, 8'h20, 64'h0); chk(rd, 64'h3c00);
			mm_acc(1'h1, 8'h08, 64'h200); @(posedge core_clk); #1;
			chk(recovery_irq_req, 1'h1);
			mm_acc(1'h1, 8'h20, 64'h0); @(posedge core_clk); #1;
			chk(recovery_irq_req, 1'h0);
		end
	endtask

	// Both requests on one edge: the window is served, the held system request follows
	task t_collide;
		begin
			@(posedge core_clk);
			mm_valid <= 1'b1; mm_write <= 1'b0; mm_addr <= 8'h60;
			sr_valid <= 1'b1; sr_write <= 1'b0; sr_cmd <= 3'h0;
			@(posedge core_clk);
			mm_valid <= 1'b0;
			#1;
			chk(mm_done, 1'h1); chk(sr_done, 1'h0);
			@(posedge core_clk);
			sr_valid <= 1'b0;
			#1;
			chk(sr_done, 1'h1); chk(sr_rdata, 64'h3);
		end
	endtask

	initial begin
		n_mismatch = 0; checks = 0; reset_n = 1'b0; er_reset = 1'b0; ce_event = 4'h0;
		mm_valid = 1'b0; mm_write = 1'b0; mm_addr = 8'h00; mm_wdata = 64'h0;
		sr_valid = 1'b0; sr_write = 1'b0; sr_cmd = 3'h0; sr_wdata = 64'h0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		chk(fault_irq_req, 1'h0); chk(recovery_irq_req, 1'h0);
		t_feature;
		t_counter;
		t_sysreg;
		t_irq;
		t_collide;
		stop_test;
	end
endmodule // tb_ras_error_record_counter
